/* File: hw/cwe_pkg.sv */
// Constants and carrier types for the card window enable and I/O control block.
// Assumes a 10 MHz bus clock and a 32-bit classic Wishbone register port.
package cwe_pkg;

    // Clock and ISA cycle timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int ISA_CYCLE_NS = 120;
    // Least time, so rounded up to whole clocks
    localparam int ISA_DIV = (ISA_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_WIN_EN = 12'h806;
    localparam logic [11:0] IDX_IO_CTRL = 12'h807;
    localparam logic [11:0] IDX_IO0_START_LO = 12'h808;
    localparam logic [11:0] IDX_IO0_START_HI = 12'h809;
    localparam logic [11:0] IDX_IO0_END_LO = 12'h80a;
    localparam logic [11:0] IDX_IO0_END_HI = 12'h80b;
    localparam logic [11:0] IDX_IO1_START_LO = 12'h80c;
    localparam logic [11:0] IDX_IO1_START_HI = 12'h80d;
    localparam logic [11:0] IDX_IO1_END_LO = 12'h80e;
    localparam logic [11:0] IDX_IO1_END_HI = 12'h80f;

    // Window enable field positions
    localparam int BIT_IO_WIN1_ON = 7;
    localparam int BIT_IO_WIN0_ON = 6;
    localparam int BIT_WIN_RSVD = 5;
    localparam int BIT_MEM_WIN_TOP = 4;
    localparam logic [7:0] WIN_EN_WRITABLE = 8'hdf;

    // I/O control field positions
    localparam int BIT_IO1_EXTRA_WAIT = 7;
    localparam int BIT_IO1_SHORT_8BIT = 6;
    localparam int BIT_IO1_AUTO_SIZE = 5;
    localparam int BIT_IO1_WIDTH_16 = 4;
    localparam int BIT_IO0_EXTRA_WAIT = 3;
    localparam int BIT_IO0_SHORT_8BIT = 2;
    localparam int BIT_IO0_AUTO_SIZE = 1;
    localparam int BIT_IO0_WIDTH_16 = 0;

    // Values after reset
    localparam logic [7:0] WIN_EN_RESET = 8'h00;
    localparam logic [7:0] IO_CTRL_RESET = 8'h00;
    localparam logic [15:0] IO_ADDR_RESET = 16'h0000;

    // I/O cycle lengths in ISA cycles
    localparam logic [3:0] ISA_LEN_STD8 = 4'h6;
    localparam logic [3:0] ISA_LEN_SHORT8 = 4'h3;
    localparam logic [3:0] ISA_LEN_STD16 = 4'h3;
    localparam logic [3:0] ISA_LEN_EXTRA = 4'h1;

    // Host cycle request as seen by the bridge's target decoder
    typedef struct packed {
        logic start;
        logic is_io;
        logic [15:0] addr;
        logic [4:0] mem_hit;
        logic iois16;
    } cwe_host_req_t;

    // Answer to the target decoder
    typedef struct packed {
        logic claim;
        logic io_sel;
        logic width16;
        logic busy;
        logic done;
        logic [3:0] isa_len;
    } cwe_host_rsp_t;

    typedef enum logic [2:0] {
        CWE_IDLE = 3'b001,
        CWE_RUN = 3'b010,
        CWE_DONE = 3'b100
    } cwe_state_t;

endpackage

/* File: hw/cwe_window_ctrl.sv */
// Window enable and I/O window control registers with the host cycle claim logic.
// Assumes a classic Wishbone master on the register port and a target decoder
// that presents one host cycle at a time with memory window hits pre-decoded.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module cwe_window_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire cwe_pkg::cwe_host_req_t host_req_i,
    output cwe_pkg::cwe_host_rsp_t host_rsp_o,
    output logic [4:0] mem_win_on_o,
    output logic [1:0] io_win_on_o
);
    import cwe_pkg::*;

    logic [7:0] win_en_q;
    logic [7:0] io_ctrl_q;
    logic [15:0] io_start_q [2];
    logic [15:0] io_end_q [2];
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] rd_byte;
    logic req_new;
    logic [11:0] reg_idx;
    logic adr_in_space;
    logic wr_lane0;

    cwe_state_t state_q;
    cwe_state_t state_d;
    logic claim_q;
    logic io_sel_q;
    logic width16_q;
    logic done_q;
    logic [3:0] isa_len_q;
    logic [3:0] isa_cnt_q;
    logic [3:0] div_cnt_q;

    logic [1:0] io_hit;
    logic [1:0] io_w16;
    logic [3:0] io_len [2];
    logic mem_claim;
    logic io_claim;
    logic sel_win;

    // Bus request decode; address bits above the index space must be zero
    assign req_new = wb_cyc_i && wb_stb_i && !ack_q;
    assign reg_idx = wb_adr_i[13:2];
    assign adr_in_space = (wb_adr_i[15:14] == 2'h0);
    assign wr_lane0 = req_new && wb_we_i && wb_sel_i[0] && adr_in_space;

    // Acknowledge every access once, mapped or not, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req_new;
        end
    end

    // Window enables; reserved bit is masked so it can never be set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_en_q <= WIN_EN_RESET;
        end else if (ce_i && wr_lane0 && reg_idx == IDX_WIN_EN) begin
            win_en_q <= wb_dat_i[7:0] & WIN_EN_WRITABLE;
        end
    end

    // I/O sizing and timing control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_ctrl_q <= IO_CTRL_RESET;
        end else if (ce_i && wr_lane0 && reg_idx == IDX_IO_CTRL) begin
            io_ctrl_q <= wb_dat_i[7:0];
        end
    end

    // I/O window bounds, written a byte at a time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_start_q[0] <= IO_ADDR_RESET;
            io_start_q[1] <= IO_ADDR_RESET;
            io_end_q[0] <= IO_ADDR_RESET;
            io_end_q[1] <= IO_ADDR_RESET;
        end else if (ce_i && wr_lane0) begin
            case (reg_idx)
                IDX_IO0_START_LO: io_start_q[0][7:0] <= wb_dat_i[7:0];
                IDX_IO0_START_HI: io_start_q[0][15:8] <= wb_dat_i[7:0];
                IDX_IO0_END_LO: io_end_q[0][7:0] <= wb_dat_i[7:0];
                IDX_IO0_END_HI: io_end_q[0][15:8] <= wb_dat_i[7:0];
                IDX_IO1_START_LO: io_start_q[1][7:0] <= wb_dat_i[7:0];
                IDX_IO1_START_HI: io_start_q[1][15:8] <= wb_dat_i[7:0];
                IDX_IO1_END_LO: io_end_q[1][7:0] <= wb_dat_i[7:0];
                IDX_IO1_END_HI: io_end_q[1][15:8] <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped indices read zero
    always_comb begin
        rd_byte = 8'h00;
        if (adr_in_space) begin
            case (reg_idx)
                IDX_WIN_EN: rd_byte = win_en_q;
                IDX_IO_CTRL: rd_byte = io_ctrl_q;
                IDX_IO0_START_LO: rd_byte = io_start_q[0][7:0];
                IDX_IO0_START_HI: rd_byte = io_start_q[0][15:8];
                IDX_IO0_END_LO: rd_byte = io_end_q[0][7:0];
                IDX_IO0_END_HI: rd_byte = io_end_q[0][15:8];
                IDX_IO1_START_LO: rd_byte = io_start_q[1][7:0];
                IDX_IO1_START_HI: rd_byte = io_start_q[1][15:8];
                IDX_IO1_END_LO: rd_byte = io_end_q[1][7:0];
                IDX_IO1_END_HI: rd_byte = io_end_q[1][15:8];
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // Read data held in a flop; upper lanes always zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (ce_i && req_new) begin
            dat_q <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Enable bits exported to the rest of the bridge
    assign io_win_on_o = {win_en_q[BIT_IO_WIN1_ON], win_en_q[BIT_IO_WIN0_ON]};
    assign mem_win_on_o = win_en_q[BIT_MEM_WIN_TOP:0];

    // Inclusive range compare, gated by the window enable
    always_comb begin
        io_hit[0] = io_win_on_o[0] && host_req_i.addr >= io_start_q[0]
                    && host_req_i.addr <= io_end_q[0];
        io_hit[1] = io_win_on_o[1] && host_req_i.addr >= io_start_q[1]
                    && host_req_i.addr <= io_end_q[1];
    end

    // Width per window: card's IOIS16 or the fixed size bit
    always_comb begin
        io_w16[0] = io_ctrl_q[BIT_IO0_AUTO_SIZE] ? host_req_i.iois16
                                                 : io_ctrl_q[BIT_IO0_WIDTH_16];
        io_w16[1] = io_ctrl_q[BIT_IO1_AUTO_SIZE] ? host_req_i.iois16
                                                 : io_ctrl_q[BIT_IO1_WIDTH_16];
    end

    // Cycle length: the wait bit touches only 16-bit, the short bit only 8-bit
    always_comb begin
        if (io_w16[0]) begin
            io_len[0] = io_ctrl_q[BIT_IO0_EXTRA_WAIT] ? ISA_LEN_STD16 + ISA_LEN_EXTRA
                                                      : ISA_LEN_STD16;
        end else begin
            io_len[0] = io_ctrl_q[BIT_IO0_SHORT_8BIT] ? ISA_LEN_SHORT8 : ISA_LEN_STD8;
        end
        if (io_w16[1]) begin
            io_len[1] = io_ctrl_q[BIT_IO1_EXTRA_WAIT] ? ISA_LEN_STD16 + ISA_LEN_EXTRA
                                                      : ISA_LEN_STD16;
        end else begin
            io_len[1] = io_ctrl_q[BIT_IO1_SHORT_8BIT] ? ISA_LEN_SHORT8 : ISA_LEN_STD8;
        end
    end

    // Window 0 wins if software programs overlapping I/O ranges
    assign sel_win = !io_hit[0];
    assign io_claim = host_req_i.is_io && (io_hit != 2'b00);
    assign mem_claim = !host_req_i.is_io && ((host_req_i.mem_hit & mem_win_on_o) != 5'h00);

    // Cycle sequencer next state; new requests are ignored while busy
    always_comb begin
        state_d = state_q;
        case (state_q)
            CWE_IDLE: begin
                if (host_req_i.start && io_claim) begin
                    state_d = CWE_RUN;
                end
            end
            CWE_RUN: begin
                if (isa_cnt_q == 4'h1 && div_cnt_q == 4'h1) begin
                    state_d = CWE_DONE;
                end
            end
            CWE_DONE: state_d = CWE_IDLE;
            default: state_d = CWE_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= CWE_IDLE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // Claim is a one-cycle answer to each start seen while idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            claim_q <= 1'b0;
        end else if (ce_i) begin
            claim_q <= host_req_i.start && state_q == CWE_IDLE && (io_claim || mem_claim);
        end
    end

    // Latch the chosen window, width and length when an I/O cycle starts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_sel_q <= 1'b0;
            width16_q <= 1'b0;
            isa_len_q <= 4'h0;
        end else if (ce_i && state_q == CWE_IDLE && host_req_i.start && io_claim) begin
            io_sel_q <= sel_win;
            width16_q <= io_w16[sel_win];
            isa_len_q <= io_len[sel_win];
        end
    end

    // ISA cycle counter with a clock prescaler
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            isa_cnt_q <= 4'h0;
            div_cnt_q <= 4'h0;
        end else if (ce_i) begin
            if (state_q == CWE_IDLE) begin
                isa_cnt_q <= io_len[sel_win];
                div_cnt_q <= 4'(ISA_DIV);
            end else if (state_q == CWE_RUN) begin
                if (div_cnt_q == 4'h1) begin
                    div_cnt_q <= 4'(ISA_DIV);
                    isa_cnt_q <= isa_cnt_q - 4'h1;
                end else begin
                    div_cnt_q <= div_cnt_q - 4'h1;
                end
            end
        end
    end

    // Done pulse marks the end of the timed card cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else if (ce_i) begin
            done_q <= (state_d == CWE_DONE) && (state_q == CWE_RUN);
        end
    end

    always_comb begin
        host_rsp_o.claim = claim_q;
        host_rsp_o.io_sel = io_sel_q;
        host_rsp_o.width16 = width16_q;
        host_rsp_o.busy = (state_q != CWE_IDLE);
        host_rsp_o.done = done_q;
        host_rsp_o.isa_len = isa_len_q;
    end

endmodule

`default_nettype wire

/* File: sim/cwe_window_ctrl_asserts.sv */
// Checker for the window enable and I/O control block, watching top ports only.
// Assumes one clock, synchronous active-high reset and ce_i high in normal use.
`timescale 1ns/100ps
`default_nettype none
module cwe_window_ctrl_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire cwe_pkg::cwe_host_req_t host_req_i,
    input wire cwe_pkg::cwe_host_rsp_t host_rsp_o,
    input wire logic [4:0] mem_win_on_o,
    input wire logic [1:0] io_win_on_o
);
    import cwe_pkg::*;
    logic [7:0] ctrl_q;
    logic en_rd_q;
    logic [5:0] cnt_q;
    logic take;
    assign take = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Shadow of the control byte, so width and length can be predicted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 8'h00;
        end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i[15:2] == {2'b00, IDX_IO_CTRL}) begin
            ctrl_q <= wb_dat_i[7:0];
        end
    end
    // Remembers a read of the enable byte until its ack
    always_ff @(posedge clk_i) begin
        if (take) begin
            en_rd_q <= !wb_we_i && wb_adr_i[15:2] == {2'b00, IDX_WIN_EN};
        end
    end
    // Clocks spent busy; reset between cycles so each length stands alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 6'h00;
        end else if (ce_i) begin
            cnt_q <= host_rsp_o.busy ? cnt_q + 6'h01 : 6'h00;
        end
    end
    function automatic logic [4:0] exp_io(input logic [7:0] c, input logic w, input logic b16);
        logic [3:0] f;
        logic wd;
        f = w ? c[7:4] : c[3:0];
        wd = f[1] ? b16 : f[0];
        if (wd) begin
            return {1'b1, ISA_LEN_STD16 + (f[3] ? ISA_LEN_EXTRA : 4'h0)};
        end
        return {1'b0, f[2] ? ISA_LEN_SHORT8 : ISA_LEN_STD8};
    endfunction
    sequence s_io_take;
        ce_i && host_req_i.start && host_req_i.is_io && !host_rsp_o.busy;
    endsequence
    sequence s_io_claim;
        s_io_take ##1 host_rsp_o.claim;
    endsequence
    a_reset_clears: assert property (disable iff (1'b0) rst_i && ce_i |=>
        mem_win_on_o == 5'h00 && io_win_on_o == 2'b00 && !wb_ack_o) else $error("reset left state");
    a_ack_one_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
    a_rsvd_bit_zero: assert property (wb_ack_o && en_rd_q |-> !wb_dat_o[5])
        else $error("reserved bit set");
    a_enable_readback: assert property (wb_ack_o && en_rd_q |->
        wb_dat_o[7:0] == {io_win_on_o, 1'b0, mem_win_on_o}) else $error("enable readback");
    a_mem_needs_on: assert property (ce_i && host_req_i.start && !host_req_i.is_io &&
        !host_rsp_o.busy && (host_req_i.mem_hit & mem_win_on_o) == 5'h00 |=> !host_rsp_o.claim)
        else $error("memory claim while off");
    a_io_needs_on: assert property (s_io_claim |->
        host_rsp_o.busy && io_win_on_o[host_rsp_o.io_sel]) else $error("io claim while off");
    a_width_and_len: assert property (s_io_claim |-> {host_rsp_o.width16, host_rsp_o.isa_len} ==
        exp_io(ctrl_q, host_rsp_o.io_sel, $past(host_req_i.iois16))) else $error("width or length");
    a_done_on_count: assert property (host_rsp_o.done |->
        cnt_q == 6'(ISA_DIV * host_rsp_o.isa_len)) else $error("cycle length");
    a_busy_after_done: assert property ($fell(host_rsp_o.busy) |-> $past(host_rsp_o.done))
        else $error("busy fell early");
endmodule
bind cwe_window_ctrl cwe_window_ctrl_chk u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_req_i(host_req_i),
    .host_rsp_o(host_rsp_o), .mem_win_on_o(mem_win_on_o), .io_win_on_o(io_win_on_o)
);
`default_nettype wire

/* File: sim/cwe_card_model.sv */
// Behavioural 16-bit card that drives its IOIS16 line as the bench asks.
// Assumes the bench sets the wanted width at least one edge before a cycle.
`timescale 1ns/100ps
`default_nettype none
module cwe_card_model (
    input wire logic clk_i,
    input wire logic want16_i,
    output logic iois16_o
);
    // Card decodes its own address, so the line settles a clock late
    always_ff @(posedge clk_i) begin
        iois16_o <= want16_i;
    end
endmodule
`default_nettype wire

/* File: sim/card_window_enable_io_control_test.sv */
// Self-checking bench: Wishbone register access plus random host cycles.
// Assumes the bound checker and the card model are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module card_window_enable_io_control_test;
    import cwe_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic start = 1'b0;
    logic is_io = 1'b0;
    logic [15:0] haddr = 16'h0000;
    logic [4:0] hit = 5'h00;
    logic want16 = 1'b0;
    logic io16;
    cwe_host_rsp_t rsp;
    logic [4:0] mem_on;
    logic [1:0] io_on;
    int fail_count = 0;
    int compares = 0;
    integer seed = 32'hbb30;
    cwe_window_ctrl dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .host_req_i({start, is_io, haddr, hit, io16}), .host_rsp_o(rsp),
        .mem_win_on_o(mem_on), .io_win_on_o(io_on)
    );
    cwe_card_model card (.clk_i(clk_i), .want16_i(want16), .iois16_o(io16));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One classic cycle; request held until ack is seen at an edge
    task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                      output logic [7:0] rd);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'b00, idx, 2'b00};
        wdat <= {24'h000000, d};
        // No cap here: only the watchdog may end a wait for ack
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Card width set two edges ahead so IOIS16 is settled at the take edge
    task automatic host(input logic io, input logic [15:0] a, input logic [4:0] h,
                        input logic b16, output logic cl, output int n);
        @(posedge clk_i);
        want16 <= b16;
        @(posedge clk_i);
        start <= 1'b1;
        is_io <= io;
        haddr <= a;
        hit <= h;
        @(posedge clk_i);
        start <= 1'b0;
        #1;
        cl = rsp.claim;
        n = 0;
        while (cl === 1'b1 && rsp.done !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        @(posedge clk_i);
    endtask
    function automatic logic [4:0] exp_io(input logic [7:0] c, input logic w, input logic b16);
        logic [3:0] f;
        logic wd;
        f = w ? c[7:4] : c[3:0];
        wd = f[1] ? b16 : f[0];
        if (wd) begin
            return {1'b1, ISA_LEN_STD16 + (f[3] ? ISA_LEN_EXTRA : 4'h0)};
        end
        return {1'b0, f[2] ? ISA_LEN_SHORT8 : ISA_LEN_STD8};
    endfunction
    initial begin
        #(100 * 6000);
        fail_count++;
        print_verdict();
    end
    initial begin
        logic [7:0] rd;
        logic [7:0] c;
        logic [31:0] r;
        logic [4:0] e;
        logic cl;
        logic inr;
        int n;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, IDX_WIN_EN, 8'h00, rd);
        chk(rd, 8'h00);
        chk({io_on, mem_on}, 7'h00);
        wb(1'b0, IDX_IO_CTRL, 8'h00, rd);
        chk(rd, 8'h00);
        wb(1'b1, IDX_WIN_EN, 8'hff, rd);
        wb(1'b0, IDX_WIN_EN, 8'h00, rd);
        chk(rd, 8'hdf);
        wb(1'b1, 12'h0ff, 8'h5a, rd);
        wb(1'b0, 12'h0ff, 8'h00, rd);
        chk(rd, 8'h00);
        // Windows 0x0100-0x01ff and 0x0300-0x03ff, 0x02xx lies between
        wb(1'b1, IDX_IO0_START_HI, 8'h01, rd);
        wb(1'b1, IDX_IO0_END_HI, 8'h01, rd);
        wb(1'b1, IDX_IO0_END_LO, 8'hff, rd);
        wb(1'b1, IDX_IO1_START_HI, 8'h03, rd);
        wb(1'b1, IDX_IO1_END_HI, 8'h03, rd);
        wb(1'b1, IDX_IO1_END_LO, 8'hff, rd);
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            c = (i < 2) ? {8{i[0]}} : r[15:8];
            wb(1'b1, IDX_WIN_EN, r[7:0], rd);
            chk({io_on, 1'b0, mem_on}, r[7:0] & WIN_EN_WRITABLE);
            wb(1'b1, IDX_IO_CTRL, c, rd);
            wb(1'b0, IDX_IO_CTRL, 8'h00, rd);
            chk(rd, c);
            host(1'b0, 16'h0000, 5'h01 << (i % 5), 1'b0, cl, n);
            chk(cl, r[i % 5]);
            inr = (i % 4) != 3;
            host(1'b1, {6'h00, r[16], inr, (i < 8) ? {8{i[0]}} : r[31:24]}, 5'h00, r[17], cl, n);
            chk(cl, inr & r[6 + r[16]]);
            if (cl === 1'b1) begin
                e = exp_io(c, r[16], r[17]);
                chk(rsp.io_sel, r[16]);
                chk({rsp.width16, rsp.isa_len}, e);
                chk(n, ISA_DIV * e[3:0]);
            end
        end
        print_verdict();
    end
endmodule
`default_nettype wire
